// ### logic/chsc_regs.sv
// status and control register pair of the charger, with host watchdog
// assumes the serial bus slave decodes byte reads and writes upstream
`timescale 1ns/1ps
`include "chsc_defs.svh"

module chsc_regs #(
    parameter int unsigned TICK_CYC  = `CHSC_CLK_HZ / `CHSC_TICK_HZ,
    parameter int unsigned WD_TICKS  = `CHSC_WD_S * `CHSC_TICK_HZ,
    parameter int unsigned FQ_DEPTH  = 4,
    parameter bit          WATCHDOG_ENABLE_RST = 1'b0
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    // register access
    input  wire logic                acc_wr,
    input  wire logic                acc_rd,
    input  wire logic [7:0]          acc_addr,
    input  wire logic [7:0]          acc_wdata,
    output logic      [7:0]          acc_rdata_ff,
    // charger core
    input  wire chsc_pkg::chsc_cond_t cond,
    output chsc_pkg::chsc_out_t      ctl_ff,
    // open-drain status pin
    output logic                     stat_pin_o_ff,
    output logic                     stat_pin_oe_ff
);

    localparam int unsigned PW = (FQ_DEPTH > 1) ? $clog2(FQ_DEPTH) : 1;
    localparam chsc_pkg::chsc_ctrl_t CTRL_DEF =
        {`CHSC_INPUT_LIMIT_RESISTOR_DEF, `CHSC_CTRL_LOW};

    logic                   watchdog_enable_ff;
    logic                   wd_flag_ff;
    chsc_pkg::chsc_ctrl_t   ctrl_ff;
    chsc_pkg::chsc_mode_t   mode_ff;
    logic [31:0]            tick_cnt_ff;
    logic [31:0]            wd_cnt_ff;
    logic [3:0]             fq_ff [FQ_DEPTH];
    logic [PW-1:0]          wp_ff;
    logic [PW-1:0]          rp_ff;
    logic [PW:0]            cnt_ff;
    logic                   ldo_lvl_ff;
    logic                   ldo_pend_ff;

    logic       wr_stat;
    logic       wr_ctrl;
    logic       soft_rst;
    logic       tick;
    logic       wd_restart;
    logic       wd_expire;
    logic       ldo_lvl;
    logic       push;
    logic [3:0] push_code;
    logic       pop;
    logic       full;
    logic [3:0] flt_field;
    logic [1:0] st_field;

    // access decode
    assign wr_stat  = acc_wr && acc_addr == `CHSC_ADDR_STAT;
    assign wr_ctrl  = acc_wr && acc_addr == `CHSC_ADDR_CTRL;
    assign soft_rst = wr_ctrl && acc_wdata[`CHSC_BIT_RST];

    // watchdog: millisecond tick, then tick count
    assign tick = tick_cnt_ff == TICK_CYC - 1;
    assign wd_restart = acc_wr
        || (wr_stat && acc_wdata[`CHSC_BIT_WDEN]);
    assign wd_expire = watchdog_enable_ff && mode_ff == chsc_pkg::CHSC_HOST
        && tick && wd_cnt_ff == WD_TICKS - 1 && !wd_restart;

    always_ff @(posedge clk_sys) begin
        if (!rstn || tick) begin
            tick_cnt_ff <= 32'h0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn || wd_restart || !watchdog_enable_ff || wd_expire) begin
            wd_cnt_ff <= 32'h0;
        end else if (tick && mode_ff == chsc_pkg::CHSC_HOST) begin
            wd_cnt_ff <= wd_cnt_ff + 32'h1;
        end
    end

    // host mode entered by any write, left on expiry
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mode_ff <= chsc_pkg::CHSC_STANDALONE;
        end else if (acc_wr) begin
            mode_ff <= chsc_pkg::CHSC_HOST;
        end else if (wd_expire) begin
            mode_ff <= chsc_pkg::CHSC_STANDALONE;
        end
    end

    // sticky timeout flag
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wd_flag_ff <= 1'b0;
        end else if (wd_expire) begin
            wd_flag_ff <= 1'b1;
        end else if (soft_rst) begin
            wd_flag_ff <= 1'b0;
        end
    end

    // watchdog enable
    always_ff @(posedge clk_sys) begin
        if (!rstn || soft_rst) begin
            watchdog_enable_ff <= WATCHDOG_ENABLE_RST;
        end else if (wr_stat) begin
            watchdog_enable_ff <= acc_wdata[`CHSC_BIT_WDEN];
        end
    end

    // control register
    always_ff @(posedge clk_sys) begin
        if (!rstn || soft_rst || wd_expire) begin
            ctrl_ff <= CTRL_DEF;
        end else if (wr_ctrl) begin
            ctrl_ff <= acc_wdata[6:0];
        end
    end

    // regulator-low fault: held until pushed, lost if the queue is full
    assign ldo_lvl = cond.internal_regulator_low
        && (cond.below_undervoltage_lockout
            || cond.leaving_undervoltage_lockout);
    assign push      = cond.flt_evt || ldo_pend_ff;
    assign push_code = cond.flt_evt ? cond.flt_code : `CHSC_FLT_LDO;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ldo_lvl_ff  <= 1'b0;
            ldo_pend_ff <= 1'b0;
        end else begin
            ldo_lvl_ff  <= ldo_lvl;
            ldo_pend_ff <= (ldo_lvl && !ldo_lvl_ff)
                || (ldo_pend_ff && cond.flt_evt);
        end
    end

    // fault queue, one code popped per status read
    assign full = cnt_ff == (PW+1)'(FQ_DEPTH);
    assign pop  = acc_rd && acc_addr == `CHSC_ADDR_STAT
        && cnt_ff != '0;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push && !full) begin
                wp_ff <= (wp_ff == PW'(FQ_DEPTH - 1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == PW'(FQ_DEPTH - 1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (PW+1)'(push && !full)
                - (PW+1)'(pop);
        end
    end

    for (genvar i = 0; i < FQ_DEPTH; i++) begin : g_fq
        always_ff @(posedge clk_sys) begin
            if (!rstn) begin
                fq_ff[i] <= `CHSC_FLT_NORMAL;
            end else if (push && !full && wp_ff == PW'(i)) begin
                fq_ff[i] <= push_code;
            end
        end
    end

    // status fields
    always_comb begin
        if (cnt_ff != '0) begin
            flt_field = fq_ff[rp_ff];
        end else if (ldo_lvl) begin
            flt_field = `CHSC_FLT_LDO;
        end else if (cond.flt_active) begin
            flt_field = cond.act_code;
        end else begin
            flt_field = `CHSC_FLT_NORMAL;
        end
    end

    always_comb begin
        if (flt_field != `CHSC_FLT_NORMAL) begin
            st_field = `CHSC_ST_FAULT;
        end else if (cond.charging) begin
            st_field = `CHSC_ST_CHG;
        end else if (cond.chg_done && ctrl_ff.term_en) begin
            st_field = `CHSC_ST_DONE;
        end else begin
            st_field = `CHSC_ST_READY;
        end
    end

    // read data; soft reset bit reads zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acc_rdata_ff <= 8'h00;
        end else if (acc_rd) begin
            case (acc_addr)
                `CHSC_ADDR_STAT:
                    acc_rdata_ff <= {wd_flag_ff, watchdog_enable_ff,
                                     st_field, flt_field};
                `CHSC_ADDR_CTRL:
                    acc_rdata_ff <= {1'b0, ctrl_ff};
                default:
                    acc_rdata_ff <= 8'h00;
            endcase
        end
    end

    // controls to the charger core
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctl_ff <= '0;
        end else begin
            ctl_ff.input_limit_resistor_eff <= (mode_ff == chsc_pkg::CHSC_HOST)
                ? ctrl_ff.input_current_limit_sel
                : `CHSC_INPUT_LIMIT_RESISTOR_EXT;
            ctl_ff.production_test_mode <= mode_ff == chsc_pkg::CHSC_HOST
                && ctrl_ff.input_current_limit_sel == `CHSC_INPUT_LIMIT_RESISTOR_PTM;
            ctl_ff.term_en         <= ctrl_ff.term_en;
            ctl_ff.bat_switch_open <= ctrl_ff.chg_dis;
            ctl_ff.conv_off        <= ctrl_ff.high_impedance_standby;
            ctl_ff.host_mode       <= mode_ff == chsc_pkg::CHSC_HOST;
        end
    end

    // open-drain status pin pulls low while charging or faulted
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stat_pin_o_ff  <= 1'b0;
            stat_pin_oe_ff <= 1'b0;
        end else begin
            stat_pin_o_ff  <= 1'b0;
            stat_pin_oe_ff <= ctrl_ff.stat_en
                && (cond.charging || flt_field != `CHSC_FLT_NORMAL);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_wd_flag_set: assert property (wd_expire |=> wd_flag_ff)
        else $error("timeout did not set flag");
    a_wd_flag_hold: assert property (wd_flag_ff && !soft_rst
        |=> wd_flag_ff) else $error("timeout flag dropped");
    a_watchdog_enable_restart: assert property (wr_stat
        && acc_wdata[`CHSC_BIT_WDEN] |=> wd_cnt_ff == 32'h0)
        else $error("enable write did not restart count");
    a_soft_rst: assert property (soft_rst |=> ctrl_ff == CTRL_DEF
        && watchdog_enable_ff == WATCHDOG_ENABLE_RST) else $error("soft reset missed");
    a_ctrl_low_def: assert property (soft_rst
        |=> ctrl_ff[3:0] == `CHSC_CTRL_LOW)
        else $error("control low nibble not default");
    a_wr_restart: assert property (acc_wr
        |=> wd_cnt_ff == 32'h0 && mode_ff == chsc_pkg::CHSC_HOST)
        else $error("write did not restart watchdog");
    a_expire_dflt: assert property (wd_expire |=> ctrl_ff == CTRL_DEF
        ##1 !ctl_ff.host_mode
        && ctl_ff.input_limit_resistor_eff == `CHSC_INPUT_LIMIT_RESISTOR_EXT)
        else $error("expiry did not reload defaults");
    a_fault_state: assert property (acc_rd
        && acc_addr == `CHSC_ADDR_STAT && flt_field != `CHSC_FLT_NORMAL
        |=> acc_rdata_ff[5:4] == `CHSC_ST_FAULT)
        else $error("fault code without fault state");
    a_fault_pop: assert property (pop && !push
        |=> cnt_ff == $past(cnt_ff) - 1'b1)
        else $error("status read did not pop fault");
    a_normal_idle: assert property (cnt_ff == '0 && !ldo_lvl
        && !cond.flt_active |-> flt_field == `CHSC_FLT_NORMAL)
        else $error("normal code not shown");
    a_ldo_queue: assert property (ldo_lvl && !ldo_lvl_ff
        && !cond.flt_evt |=> ldo_pend_ff)
        else $error("regulator fault not queued");
    a_stat_gate: assert property (!ctrl_ff.stat_en
        |=> !stat_pin_oe_ff) else $error("status pin driven while off");
    a_no_done: assert property (!ctrl_ff.term_en
        |-> st_field != `CHSC_ST_DONE) else $error("done shown");
    a_hz_conv: assert property (ctrl_ff.high_impedance_standby
        && !ctrl_ff.chg_dis |=> ctl_ff.conv_off && !ctl_ff.bat_switch_open)
        else $error("standby not applied");
    a_chg_dis: assert property (ctrl_ff.chg_dis
        |=> ctl_ff.bat_switch_open) else $error("battery switch not open");
    a_ptm_host: assert property (mode_ff == chsc_pkg::CHSC_HOST
        && ctrl_ff.input_current_limit_sel == `CHSC_INPUT_LIMIT_RESISTOR_PTM
        |=> ctl_ff.production_test_mode) else $error("test mode not set");
    a_input_limit_resistor_ext: assert property (mode_ff == chsc_pkg::CHSC_STANDALONE
        |=> ctl_ff.input_limit_resistor_eff == `CHSC_INPUT_LIMIT_RESISTOR_EXT)
        else $error("standalone limit not external");

    c_expire:    cover property (wd_expire);
    c_fault_rd:  cover property (pop ##2 pop);
    c_ldo_fault: cover property (ldo_pend_ff);
    c_soft_rst:  cover property (soft_rst);
    c_host_ptm:  cover property (ctl_ff.production_test_mode);

endmodule

// ### logic/chsc_defs.svh
// constants of the charger status/control register pair
// assumes one 200 MHz clock and a byte-wide decoded register port
// Functional notes
// - status top bit shows watchdog timeout
// - watchdog timeout flag stays set until reset or soft reset
// - watchdog enable bit; writing 1 restarts count
// - watchdog enable reset value depends on variant
// - two-bit charge state: ready/charging/done/fault
// - four-bit fault code, eleven defined values
// - recorded faults read out one per read
// - all read and none active gives normal
// - regulator low during lockout gives code 1010
// - control top bit one restores all defaults
// - three-bit input limit selection incl. test
// - standalone mode uses external resistor limit
// - status pin enable gates open-drain output
// - termination enable; disabled hides done indication
// - charge disable opens battery switch
// - standby disables converter, switch stays closed
// - control low nibble resets to 1100
// - fifty second host watchdog
// - every bus write restarts the watchdog
// - expiry reloads defaults, charging continues
`ifndef CHSC_DEFS_SVH
`define CHSC_DEFS_SVH

`define CHSC_ADDR_STAT   8'h00
`define CHSC_ADDR_CTRL   8'h01
`define CHSC_BIT_FLAG    7
`define CHSC_BIT_WDEN    6
`define CHSC_BIT_RST     7
`define CHSC_CTRL_LOW    4'hC
`define CHSC_INPUT_LIMIT_RESISTOR_DEF    3'h6
`define CHSC_INPUT_LIMIT_RESISTOR_EXT    3'h6
`define CHSC_INPUT_LIMIT_RESISTOR_PTM    3'h7
`define CHSC_FLT_NORMAL  4'h0
`define CHSC_FLT_LDO     4'hA
`define CHSC_ST_READY    2'h0
`define CHSC_ST_CHG      2'h1
`define CHSC_ST_DONE     2'h2
`define CHSC_ST_FAULT    2'h3
`define CHSC_CLK_HZ      200000000
`define CHSC_TICK_HZ     1000
`define CHSC_WD_S        50

`endif

// ### logic/chsc_pkg.sv
// types of the charger status/control register pair
// assumes chsc_defs.svh for all numeric constants
package chsc_pkg;

    // control register fields below the soft reset bit
    typedef struct packed {
        logic [2:0] input_current_limit_sel;
        logic       stat_en;
        logic       term_en;
        logic       chg_dis;
        logic       high_impedance_standby;
    } chsc_ctrl_t;

    // conditions reported by the charger core
    typedef struct packed {
        logic       charging;
        logic       chg_done;
        logic       flt_evt;
        logic [3:0] flt_code;
        logic       flt_active;
        logic [3:0] act_code;
        logic       internal_regulator_low;
        logic       below_undervoltage_lockout;
        logic       leaving_undervoltage_lockout;
    } chsc_cond_t;

    // controls driven into the charger core
    typedef struct packed {
        logic [2:0] input_limit_resistor_eff;
        logic       production_test_mode;
        logic       term_en;
        logic       bat_switch_open;
        logic       conv_off;
        logic       host_mode;
    } chsc_out_t;

    typedef enum logic [1:0] {
        CHSC_STANDALONE = 2'b01,
        CHSC_HOST       = 2'b10
    } chsc_mode_t;

endpackage

// ### tb/chsc_host_model.sv
// host-side bus controller model driving byte register accesses
// assumes single-cycle strobes sampled on the rising clock edge
`timescale 1ns/1ps
module chsc_host_model (
    // clock
    input  wire logic       clk_sys,
    // register access
    output logic            acc_wr,
    output logic            acc_rd,
    output logic [7:0]      acc_addr,
    output logic [7:0]      acc_wdata,
    input  wire logic [7:0] acc_rdata_ff
);
    initial begin
        acc_wr    = 1'b0;
        acc_rd    = 1'b0;
        acc_addr  = 8'h00;
        acc_wdata = 8'h00;
    end

    // one byte write, which also restarts the watchdog
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        acc_wr    = 1'b1;
        acc_addr  = addr;
        acc_wdata = data;
        @(negedge clk_sys);
        acc_wr    = 1'b0;
        acc_addr  = ~addr;
        acc_wdata = ~data;
    endtask

    // one byte read, data taken the cycle after the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        acc_rd   = 1'b1;
        acc_addr = addr;
        @(negedge clk_sys);
        acc_rd   = 1'b0;
        acc_addr = ~addr;
        data     = acc_rdata_ff;
    endtask
endmodule

// ### tb/chsc_regs_tb.sv
// self-checking bench of the charger status/control register pair
// assumes chsc_regs with shortened watchdog counts and the host model
`timescale 1ns/1ps
module chsc_regs_tb;
    logic                 clk_sys;
    logic                 rstn;
    logic                 acc_wr;
    logic                 acc_rd;
    logic [7:0]           acc_addr;
    logic [7:0]           acc_wdata;
    logic [7:0]           acc_rdata_ff;
    chsc_pkg::chsc_cond_t cond;
    chsc_pkg::chsc_out_t  ctl_ff;
    logic                 stat_pin_o_ff;
    logic                 stat_pin_oe_ff;
    logic [7:0]           rd_val;
    logic [7:0]           rdata_v;
    int                   err_total;
    int                   cmp_count;
    // write data, control readback, effective controls
    logic [23:0]          rows [5] = '{24'h00_00_01, 24'h7F_7F_FF,
                                       24'h5A_5A_A5, 24'h23_23_47,
                                       24'h41_41_83};
    logic [3:0]           codes [3] = '{4'h1, 4'h5, 4'h9};

    chsc_regs #(.TICK_CYC(10), .WD_TICKS(5)) dut (
        .clk_sys        (clk_sys),
        .rstn           (rstn),
        .acc_wr         (acc_wr),
        .acc_rd         (acc_rd),
        .acc_addr       (acc_addr),
        .acc_wdata      (acc_wdata),
        .acc_rdata_ff   (acc_rdata_ff),
        .cond           (cond),
        .ctl_ff         (ctl_ff),
        .stat_pin_o_ff  (stat_pin_o_ff),
        .stat_pin_oe_ff (stat_pin_oe_ff)
    );

    // variant whose watchdog comes out of reset enabled
    chsc_regs #(.TICK_CYC(10), .WD_TICKS(5), .WATCHDOG_ENABLE_RST(1'b1)) dut_v (
        .clk_sys        (clk_sys),
        .rstn           (rstn),
        .acc_wr         (acc_wr),
        .acc_rd         (acc_rd),
        .acc_addr       (acc_addr),
        .acc_wdata      (acc_wdata),
        .acc_rdata_ff   (rdata_v),
        .cond           (cond),
        .ctl_ff         (),
        .stat_pin_o_ff  (),
        .stat_pin_oe_ff ()
    );

    chsc_host_model host (
        .clk_sys      (clk_sys),
        .acc_wr       (acc_wr),
        .acc_rd       (acc_rd),
        .acc_addr     (acc_addr),
        .acc_wdata    (acc_wdata),
        .acc_rdata_ff (acc_rdata_ff)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
        host.rd(addr, rd_val);
        chk(rd_val, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog of the run itself
    initial begin
        repeat (20000) @(negedge clk_sys);
        err_total++;
        report_and_stop();
    end

    initial begin
        err_total = 0;
        cmp_count = 0;
        rstn      = 1'b0;
        cond      = '0;
        cyc(3);
        rstn = 1'b1;
        cyc(1);
        // defaults after reset
        chk(ctl_ff, 8'hC8);
        rdc(8'h01, 8'h6C);
        rdc(8'h00, 8'h00);
        chk(rdata_v, 8'h40);
        rdc(8'h07, 8'h00);
        // ordinary control writes
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h01, rows[i][23:16]);
            cyc(1);
            chk(ctl_ff, rows[i][7:0]);
            rdc(8'h01, rows[i][15:8]);
        end
        // soft reset restores defaults
        host.wr(8'h00, 8'h40);
        rdc(8'h00, 8'h40);
        host.wr(8'h01, 8'h80);
        rdc(8'h01, 8'h6C);
        rdc(8'h00, 8'h00);
        // recorded faults read out one per read
        foreach (codes[i]) begin
            @(negedge clk_sys);
            cond.flt_evt  = 1'b1;
            cond.flt_code = codes[i];
            @(negedge clk_sys);
            cond.flt_evt  = 1'b0;
        end
        foreach (codes[i]) rdc(8'h00, {4'h3, codes[i]});
        rdc(8'h00, 8'h00);
        // live fault
        cond.flt_active = 1'b1;
        cond.act_code   = 4'h6;
        cyc(1);
        rdc(8'h00, 8'h36);
        cond.flt_active = 1'b0;
        cyc(1);
        rdc(8'h00, 8'h00);
        // regulator low in and leaving lockout
        cond.internal_regulator_low     = 1'b1;
        cond.below_undervoltage_lockout = 1'b1;
        cyc(2);
        rdc(8'h00, 8'h3A);
        cond.below_undervoltage_lockout   = 1'b0;
        cond.leaving_undervoltage_lockout = 1'b1;
        cyc(2);
        rdc(8'h00, 8'h3A);
        cond = '0;
        cyc(1);
        rdc(8'h00, 8'h00);
        // charge state and status pin
        cond.charging = 1'b1;
        cyc(2);
        chk({7'h00, stat_pin_oe_ff}, 8'h01);
        chk({7'h00, stat_pin_o_ff}, 8'h00);
        rdc(8'h00, 8'h10);
        host.wr(8'h01, 8'h64);
        cyc(2);
        chk({7'h00, stat_pin_oe_ff}, 8'h00);
        cond.charging = 1'b0;
        cond.chg_done = 1'b1;
        rdc(8'h00, 8'h20);
        host.wr(8'h01, 8'h68);
        rdc(8'h00, 8'h00);
        cond.chg_done = 1'b0;
        // watchdog restart, expiry and sticky flag
        host.wr(8'h00, 8'h40);
        cyc(30);
        host.wr(8'h01, 8'h6C);
        cyc(30);
        rdc(8'h00, 8'h40);
        cyc(60);
        host.rd(8'h00, rd_val);
        chk(rd_val & 8'h80, 8'h80);
        chk(ctl_ff, 8'hC8);
        cyc(20);
        host.rd(8'h00, rd_val);
        chk(rd_val & 8'h80, 8'h80);
        host.wr(8'h01, 8'h6C);
        host.rd(8'h00, rd_val);
        chk(rd_val & 8'h80, 8'h80);
        // mid-run reset clears flag and host mode
        rstn = 1'b0;
        cyc(3);
        rstn = 1'b1;
        cyc(1);
        chk(ctl_ff, 8'hC8);
        rdc(8'h00, 8'h00);
        chk(rdata_v, 8'h40);
        report_and_stop();
    end
endmodule
